// file: cfd_pkg.sv
`default_nettype none
package cfd_pkg;

	// ********************************************************
	// Register indices (byte address is four times the index)
	// ********************************************************
	localparam logic [5:0] IDX_MAIN_CTRL   = 6'h00;
	localparam logic [5:0] IDX_DETECT_CTRL = 6'h02;
	localparam logic [5:0] IDX_IRQ_CTRL    = 6'h03;
	localparam logic [5:0] IDX_IRQ_FLAGS   = 6'h04;
	localparam logic [5:0] IDX_EVT_STATUS  = 6'h0C;
	localparam logic [5:0] IDX_EVT_CLEAR   = 6'h0D;
	localparam logic [5:0] IDX_EVT_ENABLE  = 6'h0E;
	localparam logic [5:0] IDX_PROTECT     = 6'h0F;
	localparam logic [5:0] IDX_NONE        = 6'h3F;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int PIN_OUT_BIT = 7;
	localparam int SRC_LSB     = 2;
	localparam int TEST_BIT    = 1;
	localparam int EN_BIT      = 0;
	localparam int KIND_BIT    = 7;
	localparam int IEN_BIT     = 0;
	localparam int FLAG_BIT    = 0;
	localparam int EVT_FAIL    = 0;
	localparam int EVT_REFUSED = 1;
	localparam int EVT_W       = 2;
	localparam int NUM_SRC     = 3;

	// ********************************************************
	// Monitored source codes
	// ********************************************************
	localparam logic [1:0] SRC_MAIN = 2'h0;
	localparam logic [1:0] SRC_FAST = 2'h1;
	localparam logic [1:0] SRC_SLOW = 2'h2;

	// ********************************************************
	// Reset values and protection
	// ********************************************************
	localparam logic [7:0]       RST_BYTE     = 8'h00;
	localparam logic [1:0]       RST_SRC      = 2'h0;
	localparam logic [EVT_W-1:0] RST_EVT      = 2'h0;
	localparam logic [31:0]      RST_WORD     = 32'h0;
	localparam logic [7:0]       PROTECT_KEY  = 8'hD8;
	localparam logic [2:0]       PROTECT_WIN  = 3'h4;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] idx;
		logic [7:0] wdata;
	} cfd_req_s;

	typedef enum logic {
		ST_IDLE   = 1'b0,
		ST_RDWAIT = 1'b1
	} cfd_bus_state_e;

	function automatic logic cfd_src_valid(input logic [1:0] src);
		return src <= SRC_SLOW;
	endfunction : cfd_src_valid

endpackage : cfd_pkg
`default_nettype wire

// file: cfd_ahb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_ahb_slave
	import cfd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output cfd_req_s         req_o
);

	cfd_bus_state_e state_q, state_d;
	logic           rdy_q, rdy_d;
	logic           wr_q, wr_d;
	logic [5:0]     idx_q, idx_d;
	logic           take;
	logic           hit;

	always_comb
	begin
		take    = hsel_i & hready_i & htrans_i[1];
		hit     = (haddr_i[31:8] == 24'h0) & (haddr_i[1:0] == 2'h0) & (hsize_i == 3'h2);
		state_d = state_q;
		rdy_d   = 1'b1;
		wr_d    = 1'b0;
		idx_d   = idx_q;
		unique case (state_q)
			ST_IDLE:
			begin
				if (take)
				begin
					idx_d = hit ? haddr_i[7:2] : IDX_NONE;
					wr_d  = hwrite_i;
					if (!hwrite_i)
					begin
						// One wait state lets a prior write settle
						state_d = ST_RDWAIT;
						rdy_d   = 1'b0;
					end
				end
			end
			ST_RDWAIT:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			rdy_q   <= 1'b1;
			wr_q    <= 1'b0;
			idx_q   <= IDX_NONE;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			rdy_q   <= rdy_d;
			wr_q    <= wr_d;
			idx_q   <= idx_d;
		end
	end

	assign hreadyout_o = rdy_q;
	assign hresp_o     = 1'b0;
	assign req_o.wr    = wr_q;
	assign req_o.rd    = (state_q == ST_RDWAIT);
	assign req_o.idx   = idx_q;
	assign req_o.wdata = hwdata_i[7:0];

endmodule : cfd_ahb_slave
`default_nettype wire

// file: cfd_fail_sense.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_fail_sense
	import cfd_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	input  wire logic [NUM_SRC-1:0] clock_fail_i,
	input  wire logic [1:0]         source_i,
	input  wire logic               enable_i,
	input  wire logic               force_i,
	output logic                    fail_evt_o,
	output logic                    main_evt_o,
	output logic                    active_o
);

	logic [NUM_SRC-1:0] sel;
	logic               cond_d, cond_q;
	logic               evt_d, evt_q;
	logic               main_d, main_q;

	// ********************************************************
	// Per-source selection
	// ********************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_src
			assign sel[g] = clock_fail_i[g] & (source_i == 2'(g)) & cfd_src_valid(source_i);
		end
	endgenerate

	always_comb
	begin
		cond_d = force_i | (enable_i & (|sel));
		evt_d  = cond_d & ~cond_q;
		main_d = evt_d & (source_i == SRC_MAIN);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cond_q <= 1'b0;
			evt_q  <= 1'b0;
			main_q <= 1'b0;
		end
		else if (ce_i)
		begin
			cond_q <= cond_d;
			evt_q  <= evt_d;
			main_q <= main_d;
		end
	end

	assign fail_evt_o = evt_q;
	assign main_evt_o = main_q;
	assign active_o   = cond_q;

endmodule : cfd_fail_sense
`default_nettype wire

// file: cfd_ctrl.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
module cfd_ctrl
	import cfd_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	output logic [31:0]             hrdata_o,
	input  wire logic [NUM_SRC-1:0] clock_fail_i,
	output logic                    irq_o,
	output logic                    nmi_o,
	output logic                    main_clock_pin_out_o,
	output logic                    fail_detect_enable_o,
	output logic [1:0]              fail_monitor_source_o,
	output logic                    fail_active_o
);

	// ********************************************************
	// Signals
	// ********************************************************
	cfd_req_s         req;
	logic             fail_evt;
	logic             main_evt;
	logic             active;

	logic             pin_out_q,  pin_out_d;
	logic [1:0]       src_q,      src_d;
	logic             force_q,    force_d;
	logic             en_q,       en_d;
	logic             kind_q,     kind_d;
	logic             ien_q,      ien_d;
	logic             flag_q,     flag_d;
	logic [EVT_W-1:0] stat_q,     stat_d;
	logic [EVT_W-1:0] sen_q,      sen_d;
	logic [2:0]       win_q,      win_d;
	logic [31:0]      rdata_q,    rdata_d;
	logic             irq_q,      irq_d;
	logic             nmi_q,      nmi_d;
	logic             active_q,   active_d;

	logic             open_win;
	logic             locked;
	logic             refused;
	logic [7:0]       rbyte;

	// ********************************************************
	// Bus slave
	// ********************************************************
	cfd_ahb_slave u_bus (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hsize_i     (hsize_i),
		.hwdata_i    (hwdata_i),
		.hready_i    (hready_i),
		.hreadyout_o (hreadyout_o),
		.hresp_o     (hresp_o),
		.req_o       (req)
	);

	// ********************************************************
	// Failure sensing
	// ********************************************************
	cfd_fail_sense u_sense (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.clock_fail_i (clock_fail_i),
		.source_i     (src_q),
		.enable_i     (en_q),
		.force_i      (force_q),
		.fail_evt_o   (fail_evt),
		.main_evt_o   (main_evt),
		.active_o     (active)
	);

	// ********************************************************
	// Read mux
	// ********************************************************
	always_comb
	begin
		rbyte = RST_BYTE;
		unique case (req.idx)
			IDX_MAIN_CTRL:
			begin
				rbyte[PIN_OUT_BIT] = pin_out_q;
			end
			IDX_DETECT_CTRL:
			begin
				rbyte[SRC_LSB+1:SRC_LSB] = src_q;
				rbyte[TEST_BIT]          = force_q;
				rbyte[EN_BIT]            = en_q;
			end
			IDX_IRQ_CTRL:
			begin
				rbyte[KIND_BIT] = kind_q;
				rbyte[IEN_BIT]  = ien_q;
			end
			IDX_IRQ_FLAGS:
			begin
				rbyte[FLAG_BIT] = flag_q;
			end
			IDX_EVT_STATUS:
			begin
				rbyte[EVT_W-1:0] = stat_q;
			end
			IDX_EVT_ENABLE:
			begin
				rbyte[EVT_W-1:0] = sen_q;
			end
			IDX_PROTECT:
			begin
				rbyte[0] = open_win;
			end
			default:
			begin
				rbyte = RST_BYTE;
			end
		endcase
	end

	// ********************************************************
	// Register next state
	// ********************************************************
	always_comb
	begin
		pin_out_d = pin_out_q;
		src_d     = src_q;
		force_d   = force_q;
		en_d      = en_q;
		kind_d    = kind_q;
		ien_d     = ien_q;
		flag_d    = flag_q;
		stat_d    = stat_q;
		sen_d     = sen_q;
		rdata_d   = rdata_q;
		refused   = 1'b0;
		open_win  = (win_q != 3'h0);
		locked    = en_q & ien_q & kind_q;
		win_d     = open_win ? win_q - 3'h1 : 3'h0;

		if (req.rd)
		begin
			rdata_d = {24'h0, rbyte};
		end

		if (req.wr)
		begin
			unique case (req.idx)
				IDX_PROTECT:
				begin
					if (req.wdata == PROTECT_KEY)
					begin
						win_d = PROTECT_WIN;
					end
				end
				IDX_MAIN_CTRL:
				begin
					if (open_win)
					begin
						pin_out_d = req.wdata[PIN_OUT_BIT];
					end
					else
					begin
						refused = 1'b1;
					end
				end
				IDX_DETECT_CTRL:
				begin
					if (open_win)
					begin
						force_d = req.wdata[TEST_BIT];
						if (!locked)
						begin
							src_d = req.wdata[SRC_LSB+1:SRC_LSB];
							en_d  = req.wdata[EN_BIT];
						end
					end
					else
					begin
						refused = 1'b1;
					end
				end
				IDX_IRQ_CTRL:
				begin
					if (open_win && !locked)
					begin
						kind_d = req.wdata[KIND_BIT];
						ien_d  = req.wdata[IEN_BIT];
					end
					refused = !open_win;
				end
				IDX_IRQ_FLAGS:
				begin
					if (req.wdata[FLAG_BIT])
					begin
						flag_d = 1'b0;
					end
				end
				IDX_EVT_CLEAR:
				begin
					stat_d = stat_q & ~req.wdata[EVT_W-1:0];
				end
				IDX_EVT_ENABLE:
				begin
					sen_d = req.wdata[EVT_W-1:0];
				end
				default:
				begin
					refused = 1'b0;
				end
			endcase
		end

		// Hardware events win over a same-cycle clear
		if (fail_evt)
		begin
			flag_d           = 1'b1;
			stat_d[EVT_FAIL] = 1'b1;
		end
		if (main_evt)
		begin
			pin_out_d = 1'b0;
		end
		if (refused)
		begin
			stat_d[EVT_REFUSED] = 1'b1;
		end
	end

	// ********************************************************
	// Interrupt and failure-active outputs
	// ********************************************************
	always_comb
	begin
		nmi_d    = flag_d & ien_d & kind_d;
		irq_d    = (flag_d & ien_d & ~kind_d) | (|(stat_d & sen_d));
		active_d = active;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_out_q <= 1'b0;
			src_q     <= RST_SRC;
			force_q   <= 1'b0;
			en_q      <= 1'b0;
			kind_q    <= 1'b0;
			ien_q     <= 1'b0;
			flag_q    <= 1'b0;
			stat_q    <= RST_EVT;
			sen_q     <= RST_EVT;
			win_q     <= 3'h0;
			rdata_q   <= RST_WORD;
			irq_q     <= 1'b0;
			nmi_q     <= 1'b0;
			active_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			pin_out_q <= pin_out_d;
			src_q     <= src_d;
			force_q   <= force_d;
			en_q      <= en_d;
			kind_q    <= kind_d;
			ien_q     <= ien_d;
			flag_q    <= flag_d;
			stat_q    <= stat_d;
			sen_q     <= sen_d;
			win_q     <= win_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
			nmi_q     <= nmi_d;
			active_q  <= active_d;
		end
	end

	assign hrdata_o              = rdata_q;
	assign irq_o                 = irq_q;
	assign nmi_o                 = nmi_q;
	assign main_clock_pin_out_o  = pin_out_q;
	assign fail_detect_enable_o  = en_q;
	assign fail_monitor_source_o = src_q;
	assign fail_active_o         = active_q;

endmodule : cfd_ctrl
`default_nettype wire

// file: cfd_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_ctrl_chk
	import cfd_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               ce_i,
	input wire logic               hsel_i,
	input wire logic [1:0]         htrans_i,
	input wire logic               hwrite_i,
	input wire logic               hready_i,
	input wire logic               hreadyout_o,
	input wire logic               hresp_o,
	input wire logic [31:0]        hrdata_o,
	input wire logic [NUM_SRC-1:0] clock_fail_i,
	input wire logic               irq_o,
	input wire logic               nmi_o,
	input wire logic               fail_detect_enable_o,
	input wire logic [1:0]         fail_monitor_source_o,
	input wire logic               fail_active_o
);
	// ****************************
	// Bus, reset, lock, detection and clock-enable checks
	// ****************************
	wire logic take = hsel_i && hready_i && htrans_i[1] && ce_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_okay; hresp_o == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_rd_wait; take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait; take && hwrite_i |=> hreadyout_o; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
	property p_wait_one; !hreadyout_o && ce_i |=> hreadyout_o; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state too long");
	property p_rd_upper; $rose(hreadyout_o) |-> hrdata_o[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	property p_rd_hold; $changed(hrdata_o) |-> $rose(hreadyout_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_reset_idle; $fell(rst_i) |-> hreadyout_o && !irq_o && !nmi_o && !fail_active_o; endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	property p_lock; nmi_o && fail_detect_enable_o |=> fail_detect_enable_o && $stable(fail_monitor_source_o);
	endproperty
	a_lock: assert property (p_lock) else $error("locked field changed");
	property p_watch; disable iff (rst_i || !ce_i) fail_detect_enable_o && fail_monitor_source_o != 2'h3
		&& clock_fail_i[fail_monitor_source_o] |-> ##[1:3] fail_active_o; endproperty
	a_watch: assert property (p_watch) else $error("failure not detected");
	property p_freeze; !ce_i |=> $stable(fail_active_o) && $stable(irq_o) && $stable(nmi_o)
		&& $stable(hreadyout_o) && $stable(hrdata_o); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while enable low");
endmodule : cfd_ctrl_chk
bind cfd_ctrl cfd_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .hrdata_o(hrdata_o), .clock_fail_i(clock_fail_i), .irq_o(irq_o), .nmi_o(nmi_o),
	.fail_detect_enable_o(fail_detect_enable_o), .fail_monitor_source_o(fail_monitor_source_o),
	.fail_active_o(fail_active_o));
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import cfd_pkg::*;
;
	logic        clk_i, rst_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o, nmi_o;
	logic        main_clock_pin_out_o, fail_detect_enable_o, fail_active_o;
	logic [1:0]  htrans_i, fail_monitor_source_o;
	logic [2:0]  hsize_i, clock_fail_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rdv;
	int          n_fail, compares, s;

	cfd_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.clock_fail_i(clock_fail_i), .irq_o(irq_o), .nmi_o(nmi_o), .main_clock_pin_out_o(main_clock_pin_out_o),
		.fail_detect_enable_o(fail_detect_enable_o), .fail_monitor_source_o(fail_monitor_source_o),
		.fail_active_o(fail_active_o));

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ****************************
	// Bus and compare tasks
	// ****************************
	task complete_run;
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wait_rdy;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk_i);
			if (hreadyout_o === 1'b1)
				return;
		end
		n_fail++;
		$display("MISMATCH %0t bus hang", $time);
		complete_run;
	endtask : wait_rdy

	task ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
		htrans_i <= 2'h2;
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		hsize_i  <= 3'h2;
		wait_rdy;
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		wait_rdy;
		rdv = hrdata_o;
	endtask : ahb

	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		ahb(1'b0, a, 8'h00);
		chk(rdv, exp, what);
		chk({31'h0, hresp_o}, 32'h0, "okay response");
	endtask : rd

	task pwr(input logic [7:0] a, input logic [7:0] d);
		ahb(1'b1, 8'h3C, PROTECT_KEY);
		ahb(1'b1, a, d);
	endtask : pwr

	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	// ****************************
	// Main sequence
	// ****************************
	initial
	begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		hsel_i = 1'b1;
		htrans_i = 2'h0;
		haddr_i = 32'h0;
		hwrite_i = 1'b0;
		hsize_i = 3'h2;
		hwdata_i = 32'h0;
		clock_fail_i = 3'h0;
		n_fail = 0;
		compares = 0;
		cyc(16);
		rst_i <= 1'b0;
		cyc(1);
		rd(8'h0C, 32'h0, "irq ctrl reset");
		ahb(1'b1, 8'h0C, 8'h81);
		rd(8'h0C, 32'h0, "unprotected write");
		rd(8'h30, 32'h2, "refused event");
		ahb(1'b1, 8'h34, 8'h03);
		rd(8'h30, 32'h0, "event clear");
		ahb(1'b1, 8'h44, 8'h55);
		rd(8'h44, 32'h0, "unmapped");
		pwr(8'h0C, 8'h01);
		for (s = 0; s < 3; s++)
		begin
			pwr(8'h00, 8'h80);
			pwr(8'h08, {4'h0, s[1:0], 2'b01});
			rd(8'h08, {28'h0, s[1:0], 2'b01}, "source readback");
			chk({30'h0, fail_monitor_source_o}, s, "source out");
			chk({31'h0, fail_detect_enable_o}, 32'h1, "enable out");
			clock_fail_i <= 3'h7 ^ (3'h1 << s);
			cyc(4);
			chk({31'h0, irq_o}, 32'h0, "unselected clock");
			clock_fail_i <= 3'h7;
			cyc(4);
			chk({31'h0, irq_o}, 32'h1, "failure irq");
			rd(8'h10, 32'h1, "flag set");
			chk({31'h0, main_clock_pin_out_o}, (s == 0) ? 32'h0 : 32'h1, "clock out");
			clock_fail_i <= 3'h0;
			ahb(1'b1, 8'h10, 8'h00);
			rd(8'h10, 32'h1, "flag write 0");
			ahb(1'b1, 8'h10, 8'h01);
			rd(8'h10, 32'h0, "flag clear");
		end
		// Clock enable low freezes detection
		ce_i <= 1'b0;
		clock_fail_i <= 3'h4;
		cyc(4);
		chk({31'h0, fail_active_o}, 32'h0, "frozen by enable");
		ce_i <= 1'b1;
		cyc(4);
		chk({31'h0, fail_active_o}, 32'h1, "resumed");
		clock_fail_i <= 3'h0;
		ahb(1'b1, 8'h10, 8'h01);
		pwr(8'h08, 8'h00);
		clock_fail_i <= 3'h1;
		cyc(4);
		rd(8'h10, 32'h0, "detection off");
		chk({31'h0, fail_detect_enable_o}, 32'h0, "enable off");
		clock_fail_i <= 3'h0;
		pwr(8'h0C, 8'h00);
		pwr(8'h08, 8'h02);
		cyc(3);
		chk({31'h0, fail_active_o}, 32'h1, "forced failure");
		rd(8'h10, 32'h1, "forced flag");
		chk({31'h0, irq_o}, 32'h0, "irq blocked");
		pwr(8'h0C, 8'h01);
		cyc(2);
		chk({31'h0, irq_o}, 32'h1, "irq permitted");
		pwr(8'h0C, 8'h81);
		cyc(2);
		chk({30'h0, nmi_o, irq_o}, 32'h2, "nmi kind");
		pwr(8'h08, 8'h00);
		cyc(3);
		chk({31'h0, fail_active_o}, 32'h0, "test ended");
		rd(8'h08, 32'h0, "test bit clear");
		ahb(1'b1, 8'h10, 8'h01);
		pwr(8'h0C, 8'h00);
		ahb(1'b1, 8'h34, 8'h03);
		ahb(1'b1, 8'h38, 8'h01);
		pwr(8'h08, 8'h02);
		cyc(3);
		chk({31'h0, irq_o}, 32'h1, "event irq");
		rd(8'h30, 32'h1, "event status");
		ahb(1'b1, 8'h34, 8'h01);
		cyc(2);
		chk({31'h0, irq_o}, 32'h0, "event cleared");
		ahb(1'b1, 8'h38, 8'h00);
		pwr(8'h08, 8'h00);
		pwr(8'h08, 8'h02);
		cyc(3);
		chk({31'h0, irq_o}, 32'h0, "event masked");
		pwr(8'h08, 8'h00);
		ahb(1'b1, 8'h10, 8'h01);
		pwr(8'h0C, 8'h81);
		pwr(8'h08, 8'h05);
		pwr(8'h08, 8'h08);
		rd(8'h08, 32'h5, "detect locked");
		pwr(8'h0C, 8'h00);
		rd(8'h0C, 32'h81, "irq ctrl locked");
		pwr(8'h08, 8'h07);
		rd(8'h08, 32'h7, "test bit writable");
		cyc(3);
		chk({31'h0, nmi_o}, 32'h1, "locked nmi");
		pwr(8'h08, 8'h0A);
		rd(8'h08, 32'h7, "locked under nmi");
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		cyc(1);
		rd(8'h08, 32'h0, "detect after reset");
		pwr(8'h0C, 8'h01);
		rd(8'h0C, 32'h1, "unlocked");
		complete_run;
	end
endmodule : tb
`default_nettype wire
